// >>> igs_pkg.sv
/*
 * igs_pkg: constants, field layouts and carrier types of the IGMP snooping
 * membership table block.
 * Assumes one switch clock (MCLK, 50 MHz) and a 10-bit register address space.
 */
package igs_pkg;

	// register offsets
	localparam logic [9:0] OFS_SRCV_CFG   = 10'h00B;
	localparam logic [9:0] OFS_MAIN_CFG   = 10'h00C;
	localparam logic [9:0] OFS_MVLAN_CFG  = 10'h00D;
	localparam logic [9:0] OFS_FALLBACK   = 10'h01B;
	localparam logic [9:0] OFS_QRT_CFG    = 10'h03F;
	localparam logic [9:0] OFS_CTRL0      = 10'h11A;
	localparam logic [9:0] OFS_CTRL5      = 10'h11F;
	localparam logic [9:0] OFS_STAT0      = 10'h120;
	localparam logic [9:0] OFS_STAT5      = 10'h125;

	// configuration field positions
	localparam int MAIN_DEF_ROUTER_BIT = 0;
	localparam int MAIN_SNOOP_EN_BIT   = 1;
	localparam int MAIN_IGN_CPU_BIT    = 2;
	localparam int MVLAN_CROSS_BIT     = 14;
	localparam int FALLBACK_LSB        = 9;
	localparam int QRT_QI_LSB          = 8;
	localparam int QRT_ROB_LSB         = 6;
	localparam int QRT_DRMAP_LSB       = 0;
	localparam int CTRL5_CMD_LSB       = 4;
	localparam int STAT5_BUSY_BIT      = 15;
	localparam int STAT5_RES_LSB       = 12;

	// entry layout
	localparam int ENT_BAD_BIT  = 57;
	localparam int ENT_OCC_BIT  = 56;
	localparam int ENT_MAP_LSB  = 23;
	localparam int ENT_W        = 58;
	localparam int GID_W        = 23;
	localparam int NPORT        = 6;
	localparam int TBL_DEPTH    = 32;
	localparam int IDX_W        = 5;
	localparam logic [2:0] CPU_PORT = 3'h5;

	// table commands and results
	localparam logic [2:0] CMD_WRITE   = 3'b100;
	localparam logic [2:0] CMD_READ    = 3'b101;
	localparam logic [2:0] RES_OK      = 3'b000;
	localparam logic [2:0] RES_BAD_CMD = 3'b111;

	// frame recognition
	localparam logic [15:0] IPV4_ETYPE    = 16'h0800;
	localparam logic [3:0]  IPV4_VER      = 4'h4;
	localparam logic [7:0]  IGMP_PROTO    = 8'h02;
	localparam logic [7:0]  TYPE_QUERY    = 8'h11;
	localparam logic [7:0]  TYPE_V1_REP   = 8'h12;
	localparam logic [7:0]  TYPE_V2_REP   = 8'h16;
	localparam logic [7:0]  TYPE_LEAVE    = 8'h17;
	localparam logic [47:0] GEN_QUERY_DA  = 48'h0100_5e00_0001;
	localparam logic [24:0] GRP_MAC_PFX   = 25'h002_00bc;
	localparam logic [3:0]  CLASS_D_TOP   = 4'he;

	// timing: query interval counts in seconds
	localparam int MCLK_HZ       = 50_000_000;
	localparam int QI_UNIT_S     = 1;
	localparam int TICK_CYCLES_D = QI_UNIT_S * MCLK_HZ;

	typedef struct packed {
		logic [2:0]  src_port;
		logic [47:0] da;
		logic [15:0] etype;
		logic [3:0]  ip_ver;
		logic [7:0]  proto;
		logic [31:0] dip;
		logic [7:0]  igmp_type;
		logic [31:0] ga;
	} igs_pkt_t;

	typedef struct packed {
		logic             bad;
		logic             occ;
		logic [NPORT-1:0] map;
		logic [GID_W-1:0] gid;
	} igs_entry_t;

	typedef enum logic [0:0] {
		ACC_IDLE = 1'b0,
		ACC_EXEC = 1'b1
	} igs_acc_t;

endpackage

// >>> igs_snoop.sv
/*
 * igs_snoop: hardware IGMP v1/v2 snooping with a 32-entry membership table,
 * multicast forwarding decision and host table access through the address
 * table control/status registers.
 * Assumes an upstream parser that presents each received frame's header
 * fields for one cycle, and a management front end that turns serial
 * management port frames into single-cycle register reads and writes.
 */
`timescale 1ns/1ps

module igs_snoop
	import igs_pkg::*;
#(
	parameter int TICK_CYCLES = TICK_CYCLES_D
) (
	input  wire logic              MCLK,
	input  wire logic              RST_B,
	input  wire logic              REG_WR,
	input  wire logic              REG_RD,
	input  wire logic [9:0]        REG_ADDR,
	input  wire logic [15:0]       REG_WDATA,
	output logic      [15:0]       REG_RDATA,
	input  wire logic              PKT_VALID,
	input  wire igs_pkt_t          PKT_INFO,
	input  wire logic [TBL_DEPTH-1:0] BIST_FAIL,
	output logic                   FWD_VALID,
	output logic      [NPORT-1:0]  FWD_MAP,
	output logic                   FWD_CROSS_VLAN,
	output logic      [NPORT-1:0]  ROUTER_MAP
);

	////////////////////////////////////////////////////////////////////////
	// helpers

	// lowest set index wins
	function automatic logic [IDX_W-1:0] first_set(input logic [TBL_DEPTH-1:0] v);
		first_set = '0;
		for (int i = TBL_DEPTH - 1; i >= 0; i--) begin
			if (v[i]) begin
				first_set = IDX_W'(i);
			end
		end
	endfunction

	function automatic logic [47:0] grp_mac(input logic [31:0] ip);
		grp_mac = {GRP_MAC_PFX, ip[GID_W-1:0]};
	endfunction

	// host view of an entry: reserved bits zero, self-test fail folded in
	function automatic logic [ENT_W-1:0] ent_word(input igs_entry_t e, input logic fail);
		ent_word = {e.bad | fail, e.occ, 27'h000_0000, e.map, e.gid};
	endfunction

	////////////////////////////////////////////////////////////////////////
	// registers

	logic [15:0]      srcv_cfg;
	logic [15:0]      main_cfg;
	logic [15:0]      mvlan_cfg;
	logic [15:0]      fallback_cfg;
	logic [15:0]      qrt_cfg;
	logic [15:0]      ctrl [6];
	logic             busy;
	logic [2:0]       result;
	logic [ENT_W-1:0] rd_entry;
	igs_acc_t         acc_state;
	logic [2:0]       acc_cmd;
	logic [IDX_W-1:0] acc_idx;
	logic [15:0]      next_rdata;

	igs_entry_t       tbl [TBL_DEPTH];
	logic [1:0]       age [TBL_DEPTH];
	logic [7:0]       rtmr [NPORT];
	logic [31:0]      tick_cnt;

	wire ctrl_sel  = REG_ADDR >= OFS_CTRL0 && REG_ADDR <= OFS_CTRL5;
	wire [2:0] ctrl_i = 3'(REG_ADDR - OFS_CTRL0);
	wire stat_sel  = REG_ADDR >= OFS_STAT0 && REG_ADDR <= OFS_STAT5;
	wire [2:0] stat_i = 3'(REG_ADDR - OFS_STAT0);
	// a control 5 write while busy is stored but starts nothing
	wire launch    = REG_WR && REG_ADDR == OFS_CTRL5 && !busy;
	wire [15:0] stat5_word = {busy, result, 12'h000};
	wire [15:0] stat4_word = {11'h000, acc_idx};
	wire [15:0] stat3_word = {6'h00, rd_entry[57:48]};

	wire snoop_en   = main_cfg[MAIN_SNOOP_EN_BIT];
	wire def_router = main_cfg[MAIN_DEF_ROUTER_BIT];
	wire [NPORT-1:0] fb_map   = fallback_cfg[FALLBACK_LSB +: NPORT];
	wire [7:0]       qi       = qrt_cfg[QRT_QI_LSB +: 8];
	wire [1:0]       rob      = qrt_cfg[QRT_ROB_LSB +: 2];
	wire [NPORT-1:0] dr_map   = qrt_cfg[QRT_DRMAP_LSB +: NPORT];

	always_ff @(posedge MCLK or negedge RST_B) begin
		if (!RST_B) begin
			srcv_cfg     <= '0;
			main_cfg     <= '0;
			mvlan_cfg    <= '0;
			fallback_cfg <= '0;
			qrt_cfg      <= '0;
			for (int i = 0; i < 6; i++) begin
				ctrl[i] <= '0;
			end
		end else if (REG_WR) begin
			if (REG_ADDR == OFS_SRCV_CFG) begin
				srcv_cfg <= REG_WDATA;
			end else if (REG_ADDR == OFS_MAIN_CFG) begin
				main_cfg <= REG_WDATA;
			end else if (REG_ADDR == OFS_MVLAN_CFG) begin
				mvlan_cfg <= REG_WDATA;
			end else if (REG_ADDR == OFS_FALLBACK) begin
				fallback_cfg <= REG_WDATA;
			end else if (REG_ADDR == OFS_QRT_CFG) begin
				qrt_cfg <= REG_WDATA;
			end else if (ctrl_sel) begin
				ctrl[ctrl_i] <= REG_WDATA;
			end
		end
	end

	// read data registered; unmapped offsets read zero
	always_comb begin
		next_rdata = '0;
		if (REG_ADDR == OFS_SRCV_CFG) begin
			next_rdata = srcv_cfg;
		end else if (REG_ADDR == OFS_MAIN_CFG) begin
			next_rdata = main_cfg;
		end else if (REG_ADDR == OFS_MVLAN_CFG) begin
			next_rdata = mvlan_cfg;
		end else if (REG_ADDR == OFS_FALLBACK) begin
			next_rdata = fallback_cfg;
		end else if (REG_ADDR == OFS_QRT_CFG) begin
			next_rdata = qrt_cfg;
		end else if (ctrl_sel) begin
			next_rdata = ctrl[ctrl_i];
		end else if (stat_sel && stat_i == 3'd5) begin
			next_rdata = stat5_word;
		end else if (stat_sel && stat_i == 3'd4) begin
			next_rdata = stat4_word;
		end else if (stat_sel && stat_i == 3'd3) begin
			next_rdata = stat3_word;
		end else if (stat_sel) begin
			next_rdata = rd_entry[16 * stat_i +: 16];
		end
	end

	always_ff @(posedge MCLK or negedge RST_B) begin
		if (!RST_B) begin
			REG_RDATA <= '0;
		end else if (REG_RD) begin
			REG_RDATA <= next_rdata;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// frame classification

	wire is_ipv4   = PKT_INFO.etype == IPV4_ETYPE && PKT_INFO.ip_ver == IPV4_VER;
	wire dip_mc    = PKT_INFO.dip[31:28] == CLASS_D_TOP;
	wire ga_mc     = PKT_INFO.ga[31:28] == CLASS_D_TOP;
	wire is_igmp   = is_ipv4 && PKT_INFO.proto == IGMP_PROTO;
	wire is_gquery = is_igmp && PKT_INFO.da == GEN_QUERY_DA
		&& PKT_INFO.igmp_type == TYPE_QUERY;
	// reports count only when sent to their own group mac
	wire is_report = is_igmp && ga_mc && PKT_INFO.da == grp_mac(PKT_INFO.ga)
		&& (PKT_INFO.igmp_type == TYPE_V1_REP || PKT_INFO.igmp_type == TYPE_V2_REP);
	wire is_leave  = is_igmp && ga_mc && PKT_INFO.igmp_type == TYPE_LEAVE;
	wire is_mdata  = is_ipv4 && !is_igmp && dip_mc
		&& PKT_INFO.da == grp_mac(PKT_INFO.dip);
	wire cpu_ign   = main_cfg[MAIN_IGN_CPU_BIT] && PKT_INFO.src_port == CPU_PORT;
	wire snoop_ok  = PKT_VALID && snoop_en && !cpu_ign;
	wire snoop_upd = snoop_ok && (is_report || is_leave || is_gquery);

	wire [NPORT-1:0] src_bit = NPORT'(1) << PKT_INFO.src_port;
	wire [GID_W-1:0] key     = is_igmp ? PKT_INFO.ga[GID_W-1:0] : PKT_INFO.dip[GID_W-1:0];

	////////////////////////////////////////////////////////////////////////
	// table lookup

	logic [TBL_DEPTH-1:0] hit;
	logic [TBL_DEPTH-1:0] free;
	logic [NPORT-1:0]     learned;

	// bad entries are never matched nor allocated
	for (genvar g = 0; g < TBL_DEPTH; g++) begin : g_look
		wire bad = tbl[g].bad | BIST_FAIL[g];
		assign hit[g]  = tbl[g].occ && !bad && tbl[g].gid == key;
		assign free[g] = !tbl[g].occ && !bad;
	end

	for (genvar p = 0; p < NPORT; p++) begin : g_rport
		assign learned[p] = rtmr[p] != 8'h00;
	end

	wire [IDX_W-1:0] hit_idx  = first_set(hit);
	wire [IDX_W-1:0] free_idx = first_set(free);
	wire             any_hit  = |hit;
	wire             tbl_full = ~|free;
	assign ROUTER_MAP = def_router ? dr_map : learned;

	////////////////////////////////////////////////////////////////////////
	// forwarding decision

	logic [NPORT-1:0] next_map;
	// only igmp and group-addressed ip data get a decision
	wire              fwd_take = PKT_VALID && (is_igmp || is_mdata);

	always_comb begin
		next_map = fb_map;
		if (is_igmp && snoop_ok) begin
			if ((is_report && !any_hit && tbl_full) || is_gquery) begin
				next_map = fb_map;
			end else begin
				next_map = ROUTER_MAP;
			end
		end else if (is_mdata && snoop_en && any_hit) begin
			next_map = tbl[hit_idx].map | ROUTER_MAP;
		end
	end

	always_ff @(posedge MCLK or negedge RST_B) begin
		if (!RST_B) begin
			FWD_VALID      <= 1'b0;
			FWD_MAP        <= '0;
			FWD_CROSS_VLAN <= 1'b0;
		end else begin
			FWD_VALID      <= fwd_take;
			FWD_MAP        <= next_map & ~src_bit;
			FWD_CROSS_VLAN <= mvlan_cfg[MVLAN_CROSS_BIT] && fwd_take;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// router port timers

	// one tick per query interval unit; a timer reloads on each general query while the default router bit is clear
	wire tick = tick_cnt == 32'(TICK_CYCLES - 1);
	wire [NPORT-1:0] q_port = (snoop_ok && is_gquery && !def_router) ? src_bit : '0;

	always_ff @(posedge MCLK or negedge RST_B) begin
		if (!RST_B) begin
			tick_cnt <= '0;
			for (int p = 0; p < NPORT; p++) begin
				rtmr[p] <= '0;
			end
		end else begin
			tick_cnt <= tick ? '0 : tick_cnt + 32'd1;
			for (int p = 0; p < NPORT; p++) begin
				if (q_port[p]) begin
					rtmr[p] <= qi;
				end else if (tick && rtmr[p] != 8'h00) begin
					rtmr[p] <= rtmr[p] - 8'h01;
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// host access sequencing

	// a pending command waits out snoop updates so the table has one writer
	wire exec      = acc_state == ACC_EXEC && !snoop_upd;
	wire cmd_known = acc_cmd == CMD_WRITE || acc_cmd == CMD_READ;
	wire [ENT_W-1:0] sel_word = ent_word(tbl[acc_idx], BIST_FAIL[acc_idx]);
	wire [ENT_W-1:0] wdata = {ctrl[3][9:0], ctrl[2], ctrl[1], ctrl[0]};
	wire igs_entry_t wentry = '{bad: wdata[ENT_BAD_BIT], occ: wdata[ENT_OCC_BIT],
		map: wdata[ENT_MAP_LSB +: NPORT], gid: wdata[GID_W-1:0]};

	always_ff @(posedge MCLK or negedge RST_B) begin
		if (!RST_B) begin
			acc_state <= ACC_IDLE;
			busy      <= 1'b0;
			result    <= RES_OK;
			acc_cmd   <= '0;
			acc_idx   <= '0;
			rd_entry  <= '0;
		end else begin
			case (acc_state)
				ACC_IDLE: begin
					if (launch) begin
						acc_state <= ACC_EXEC;
						busy      <= 1'b1;
						acc_cmd   <= REG_WDATA[CTRL5_CMD_LSB +: 3];
						acc_idx   <= ctrl[4][IDX_W-1:0];
					end
				end
				ACC_EXEC: begin
					if (exec) begin
						acc_state <= ACC_IDLE;
						busy      <= 1'b0;
						result    <= cmd_known ? RES_OK : RES_BAD_CMD;
						if (acc_cmd == CMD_READ) begin
							rd_entry <= sel_word;
						end
					end
				end
				default: acc_state <= ACC_IDLE;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// membership table

	wire             host_put  = exec && acc_cmd == CMD_WRITE;
	wire             join_ev   = snoop_ok && is_report;
	wire             leave_ev  = snoop_ok && is_leave && any_hit;
	wire             query_ev  = snoop_ok && is_gquery;
	wire [NPORT-1:0] left_map  = tbl[hit_idx].map & ~src_bit;
	wire             last_left = left_map == '0;

	// a report restarts an entry's ageing count
	always_ff @(posedge MCLK or negedge RST_B) begin
		if (!RST_B) begin
			for (int i = 0; i < TBL_DEPTH; i++) begin
				tbl[i] <= '0;
				age[i] <= '0;
			end
		end else if (host_put) begin
			tbl[acc_idx] <= wentry;
			age[acc_idx] <= '0;
		end else if (join_ev) begin
			if (any_hit) begin
				tbl[hit_idx].map <= tbl[hit_idx].map | src_bit;
				age[hit_idx]     <= '0;
			end else if (!tbl_full) begin
				tbl[free_idx] <= '{bad: 1'b0, occ: 1'b1, map: src_bit, gid: key};
				age[free_idx] <= '0;
			end
		end else if (leave_ev) begin
			tbl[hit_idx].map <= left_map;
			if (last_left) begin
				tbl[hit_idx].occ <= 1'b0;
			end
		end else if (query_ev) begin
			for (int i = 0; i < TBL_DEPTH; i++) begin
				// robustness 0 frees the entry on the first query
				if (tbl[i].occ && age[i] >= rob) begin
					tbl[i].occ <= 1'b0;
				end else if (tbl[i].occ) begin
					age[i] <= age[i] + 2'd1;
				end
			end
		end
	end

endmodule

// >>> igs_snoop_props.sv
/* checker of the snooping block port behaviour.
   bound into igs_snoop from the testbench top; one clock domain. */
`timescale 1ns/1ps
module igs_snoop_props
	import igs_pkg::*;
(
	input wire logic        MCLK,
	input wire logic        RST_B,
	input wire logic        REG_WR,
	input wire logic        REG_RD,
	input wire logic [9:0]  REG_ADDR,
	input wire logic [15:0] REG_WDATA,
	input wire logic [15:0] REG_RDATA,
	input wire logic        PKT_VALID,
	input wire igs_pkt_t    PKT_INFO,
	input wire logic        FWD_VALID,
	input wire logic [5:0]  FWD_MAP,
	input wire logic        FWD_CROSS_VLAN,
	input wire logic [5:0]  ROUTER_MAP
);
	logic [15:0] main, mv, fb, qrt;
	// shadow copies of the configuration writes
	always_ff @(posedge MCLK or negedge RST_B) begin
		if (!RST_B) begin
			main <= 16'h0000;
			mv <= 16'h0000;
			fb <= 16'h0000;
			qrt <= 16'h0000;
		end else if (REG_WR) begin
			case (REG_ADDR)
			OFS_MAIN_CFG: main <= REG_WDATA;
			OFS_MVLAN_CFG: mv <= REG_WDATA;
			OFS_FALLBACK: fb <= REG_WDATA;
			OFS_QRT_CFG: qrt <= REG_WDATA;
			default: ;
			endcase
		end
	end
	wire       ip    = PKT_VALID && PKT_INFO.etype == IPV4_ETYPE && PKT_INFO.ip_ver == IPV4_VER;
	wire       igmp  = ip && PKT_INFO.proto == IGMP_PROTO;
	wire       snoop = main[1] && !(main[2] && PKT_INFO.src_port == CPU_PORT);
	wire       gq    = igmp && snoop && PKT_INFO.da == GEN_QUERY_DA
		&& PKT_INFO.igmp_type == TYPE_QUERY;
	wire [5:0] src1h = 6'h01 << PKT_INFO.src_port;
	wire [5:0] qexp  = fb[14:9] & ~src1h;
	wire       cv    = mv[14];
	////////////////////////////////////////
	default clocking cb @(posedge MCLK);
	endclocking
	default disable iff (!RST_B);
	igmp_fwd_a: assert property (igmp |=> FWD_VALID)
		else $error("igmp frame gave no decision");
	fwd_cause_a: assert property (FWD_VALID |-> $past(PKT_VALID))
		else $error("decision without a frame");
	src_mask_a: assert property (FWD_VALID |-> (FWD_MAP & $past(src1h)) == 6'h00)
		else $error("frame sent back to its source");
	query_map_a: assert property (gq |=> FWD_MAP == $past(qexp))
		else $error("query not sent on fallback map");
	non_ip_a: assert property (PKT_VALID && PKT_INFO.etype != IPV4_ETYPE |=> !FWD_VALID)
		else $error("non ip frame decided");
	cross_vlan_a: assert property (FWD_VALID |-> FWD_CROSS_VLAN == $past(cv))
		else $error("cross vlan flag wrong");
	def_router_a: assert property (main[0] |-> ROUTER_MAP == qrt[5:0])
		else $error("default router map not used");
	router_learn_a: assert property (gq && !main[0] && qrt[15:8] != 8'h00
		|=> (ROUTER_MAP & $past(src1h)) != 6'h00)
		else $error("query port not learned");
	cfg_read_a: assert property (REG_RD && REG_ADDR == OFS_MAIN_CFG |=> REG_RDATA == $past(main))
		else $error("main config read back wrong");
	rdata_hold_a: assert property (!REG_RD |=> $stable(REG_RDATA))
		else $error("read data changed without a read");
	cover property (gq);
	cover property (REG_WR && REG_ADDR == OFS_CTRL5);
	cover property (FWD_VALID && FWD_MAP != 6'h00);
endmodule

// >>> igs_host_model.sv
/* host processor model: register strobes and membership table commands.
   assumes the block samples strobes on rising mclk, read data one cycle later. */
`timescale 1ns/1ps
module igs_host_model
	import igs_pkg::*;
(
	input  wire logic        mclk,
	output logic             reg_wr,
	output logic             reg_rd,
	output logic [9:0]       reg_addr,
	output logic [15:0]      reg_wdata,
	input  wire logic [15:0] reg_rdata
);
	initial begin
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 10'h000;
		reg_wdata = 16'h0000;
	end
	task automatic wr(input logic [9:0] a, input logic [15:0] d);
		@(posedge mclk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge mclk);
		reg_wr <= 1'b0;
		// released lines never keep the last value
		reg_addr <= ~a;
		reg_wdata <= ~d;
	endtask
	task automatic rd(input logic [9:0] a, output logic [15:0] d);
		@(posedge mclk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge mclk);
		reg_rd <= 1'b0;
		reg_addr <= ~a;
		@(negedge mclk);
		d = reg_rdata;
	endtask
	task automatic tbl(input logic [2:0] c, input logic [4:0] i, input logic [57:0] w,
		output logic [57:0] r, output logic [2:0] res, output logic [4:0] ri);
		logic [63:0] x;
		logic [15:0] s;
		bit done;
		res = 3'hx;
		x = {6'h00, w};
		for (int k = 0; k < 4; k++) wr(OFS_CTRL0 + 10'(k), x[16*k +: 16]);
		wr(OFS_CTRL0 + 10'h004, {11'h000, i});
		wr(OFS_CTRL5, {9'h000, c, 4'h0});
		for (int k = 0; k < 20 && !done; k++) begin
			rd(OFS_STAT5, s);
			if (!s[15]) begin
				done = 1'b1;
				res = s[14:12];
			end
		end
		for (int k = 0; k < 4; k++) begin
			rd(OFS_STAT0 + 10'(k), s);
			x[16*k +: 16] = s;
		end
		r = x[57:0];
		rd(OFS_STAT0 + 10'h004, s);
		ri = s[4:0];
	endtask
endmodule

// >>> igs_snoop_tb.sv
/* self-checking testbench of igs_snoop with host model and checker.
   assumes a 50 MHz clock and a router timer tick shortened to 16 cycles. */
`timescale 1ns/1ps
module igs_snoop_tb
	import igs_pkg::*;
;
	localparam int TICK = 16;
	localparam logic [9:0] CFG [5] = '{OFS_SRCV_CFG, OFS_MAIN_CFG, OFS_MVLAN_CFG,
		OFS_FALLBACK, OFS_QRT_CFG};
	logic        mclk, rst_b, reg_wr, reg_rd, pkt_valid, fwd_valid, fwd_cross_vlan, xv;
	logic [9:0]  reg_addr;
	logic [15:0] reg_wdata, reg_rdata, d;
	logic [31:0] bist_fail, g;
	logic [5:0]  fwd_map, router_map, m;
	logic [57:0] r;
	logic [2:0]  res;
	logic [4:0]  ri;
	igs_pkt_t    pkt_info;
	int          n_mismatch, n_compared, seed;
	igs_snoop #(.TICK_CYCLES(TICK)) DUT (.MCLK(mclk), .RST_B(rst_b), .REG_WR(reg_wr),
		.REG_RD(reg_rd), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata), .REG_RDATA(reg_rdata),
		.PKT_VALID(pkt_valid), .PKT_INFO(pkt_info), .BIST_FAIL(bist_fail),
		.FWD_VALID(fwd_valid), .FWD_MAP(fwd_map), .FWD_CROSS_VLAN(fwd_cross_vlan),
		.ROUTER_MAP(router_map));
	igs_host_model host (.mclk, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata);
	initial begin
		mclk = 1'b0;
		forever #10 mclk = ~mclk;
	end
	////////////////////////////////////////
	function automatic logic [57:0] ent(logic b, logic o, logic [5:0] mp, logic [22:0] id);
		return {b, o, 27'h000_0000, mp, id};
	endfunction
	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		n_compared++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic print_verdict;
		$display("mismatches %0d compared %0d", n_mismatch, n_compared);
		if (n_mismatch == 0 && n_compared > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	task automatic send(input logic [2:0] s, input logic [7:0] p, input logic [7:0] t,
		input logic [31:0] a);
		@(posedge mclk);
		pkt_valid <= 1'b1;
		pkt_info <= '{s, (t == TYPE_QUERY) ? GEN_QUERY_DA : {GRP_MAC_PFX, a[22:0]},
			(p == 8'h00) ? 16'h0806 : IPV4_ETYPE, IPV4_VER, p, a, t,
			(t == TYPE_QUERY) ? 32'h0000_0000 : a};
		@(posedge mclk);
		pkt_valid <= 1'b0;
		pkt_info <= ~pkt_info;
		@(negedge mclk);
		chk(fwd_valid, p != 8'h00);
		chk(fwd_cross_vlan, p != 8'h00 && xv);
		m = fwd_map;
	endtask
	task automatic rd_ent(input logic [4:0] i, input logic [57:0] e);
		host.tbl(CMD_READ, i, 58'h0, r, res, ri);
		chk(res, RES_OK);
		chk(ri, i);
		chk(r, e);
	endtask
	////////////////////////////////////////
	initial begin
		repeat (100000) @(posedge mclk);
		n_mismatch++;
		print_verdict;
	end
	initial begin
		seed = 26355;
		rst_b = 1'b0;
		pkt_valid = 1'b0;
		pkt_info = '0;
		bist_fail = 32'h8000_0000;
		repeat (16) @(posedge mclk);
		rst_b <= 1'b1;
		for (int k = 0; k < 5; k++) begin
			d = $random(seed);
			host.wr(CFG[k], d);
			host.rd(CFG[k], r[15:0]);
			chk(r[15:0], d);
		end
		host.rd(10'h3ff, d);
		chk(d, 16'h0000);
		host.wr(OFS_STAT5, 16'hffff);
		host.rd(OFS_STAT5, d);
		chk(d, 16'h0000);
		// fill every entry; the last one fails self test
		for (int i = 0; i < 32; i++) begin
			g = $random(seed);
			host.tbl(CMD_WRITE, 5'(i), ent(1'b0, 1'b1, g[28:23], {1'b0, g[21:0]}), r, res, ri);
			chk(res, RES_OK);
			rd_ent(5'(i), ent(i == 31, 1'b1, g[28:23], {1'b0, g[21:0]}));
		end
		host.tbl(3'h6, 5'h03, 58'h0, r, res, ri);
		chk(res, RES_BAD_CMD);
		host.wr(OFS_MAIN_CFG, 16'h0002);
		host.wr(OFS_FALLBACK, 16'h5200);
		host.wr(OFS_QRT_CFG, 16'h0200);
		host.wr(OFS_MVLAN_CFG, 16'h4000);
		xv = 1'b1;
		g = $random(seed);
		g[31:28] = 4'he;
		g[22] = 1'b1;
		send(3'h0, IGMP_PROTO, TYPE_V2_REP, g);
		chk(m, 6'h28);
		for (int i = 0; i < 32; i++) begin
			host.tbl(CMD_WRITE, 5'(i), 58'h0, r, res, ri);
			chk(res, RES_OK);
		end
		// join from two ports, alias group, then leave
		send(3'h2, IGMP_PROTO, TYPE_V1_REP, g);
		chk(m, 6'h00);
		send(3'h3, IGMP_PROTO, TYPE_V2_REP, g);
		rd_ent(5'h00, ent(1'b0, 1'b1, 6'h0c, g[22:0]));
		g[27:23] = ~g[27:23];
		send(3'h0, 8'h11, 8'h00, g);
		chk(m, 6'h0c);
		send(3'h2, IGMP_PROTO, TYPE_LEAVE, g);
		rd_ent(5'h00, ent(1'b0, 1'b1, 6'h08, g[22:0]));
		send(3'h3, IGMP_PROTO, TYPE_LEAVE, g);
		send(3'h1, 8'h11, 8'h00, g);
		chk(m, 6'h29);
		host.wr(OFS_MAIN_CFG, 16'h0000);
		send(3'h1, IGMP_PROTO, TYPE_V2_REP, g);
		host.wr(OFS_MAIN_CFG, 16'h0006);
		send(3'h5, IGMP_PROTO, TYPE_V2_REP, g);
		send(3'h0, 8'h11, 8'h00, g);
		chk(m, 6'h28);
		host.wr(OFS_MAIN_CFG, 16'h0002);
		send(3'h5, IGMP_PROTO, TYPE_V2_REP, g);
		send(3'h0, 8'h11, 8'h00, g);
		chk(m, 6'h20);
		host.wr(OFS_MVLAN_CFG, 16'h0000);
		xv = 1'b0;
		// general query learns a router and ages the group out
		send(3'h4, IGMP_PROTO, TYPE_QUERY, 32'he000_0001);
		chk(m, 6'h29);
		chk(router_map, 6'h10);
		send(3'h0, 8'h11, 8'h00, g);
		chk(m, 6'h28);
		repeat (2 * TICK + 20) @(posedge mclk);
		@(negedge mclk);
		chk(router_map, 6'h00);
		host.wr(OFS_QRT_CFG, 16'h0221);
		host.wr(OFS_MAIN_CFG, 16'h0003);
		@(negedge mclk);
		chk(router_map, 6'h21);
		send(3'h0, 8'h00, 8'h00, g);
		@(posedge mclk);
		rst_b <= 1'b0;
		repeat (2) @(posedge mclk);
		rst_b <= 1'b1;
		host.rd(OFS_MAIN_CFG, d);
		chk(d, 16'h0000);
		print_verdict;
	end
endmodule

bind igs_snoop igs_snoop_props u_props (.MCLK, .RST_B, .REG_WR, .REG_RD, .REG_ADDR,
	.REG_WDATA, .REG_RDATA, .PKT_VALID, .PKT_INFO, .FWD_VALID, .FWD_MAP, .FWD_CROSS_VLAN,
	.ROUTER_MAP);
